// ### design/sfr_map.svh
// register map, field positions and timing constants of the status flag unit
// Operation
// - reading either null register keeps serial data output low throughout
// - writes to either null register are dropped, no state changes
// - status register is read-only, reports every flag regardless of masks
// - each status flag reads one when asserted, zero when inactive
// - lowest status byte carries detail bits refining the upper flags
// - ecg fifo flag follows stored records at or above threshold
// - ecg overflow sets on overflow, clears on fifo reset or resync
// - fast-recovery flag asserts when recovery engages; clear mode selects clearing
// - dc lead-off flag asserts after lead-off lasts more than 90 ms
// - sticky flags hold while condition persists, clear on 32nd status clock
// - bioz fifo flag follows stored records at or above bioz threshold
// - bioz overflow sets on overflow, clears on fifo reset or resync
// - over-range flag asserts after 100 ms above high threshold, sticky
// - under-range flag asserts after 1.7 s within low threshold, sticky
// - drive monitor flag asserts after 128 ms lead-off on either generator
// - pacing fifo flag stays set while pacing records remain
// - pacing overflow sets on overflow, clears on fifo reset or resync
// - pacing edge flag marks edges in real time; clear mode selects clearing
// - leads-on flag asserts on mode 01/10; one status read arms detection
// - armed leads-on flag follows condition then holds until status read
// - pll flag asserts only with a channel enabled and lock absent, sticky
// - four dc lead-off detail bits assert together with the lead-off flag
// - active-low irq outputs OR the flags enabled in each mask, masks reset zero
// - r-event flag asserts on each new r event; clear mode selects clearing
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

`define SFR_ADDR_NULL_LO   7'h00
`define SFR_ADDR_STATUS    7'h01
`define SFR_ADDR_MASK_PRI  7'h02
`define SFR_ADDR_MASK_SEC  7'h03
`define SFR_ADDR_NULL_HI   7'h7f

`define SFR_FRAME_LAST     6'h1f
`define SFR_CMD_LAST       6'h07

`define SFR_BIT_ECG_IRQ    23
`define SFR_BIT_ECG_OVF    22
`define SFR_BIT_FAST       21
`define SFR_BIT_DCLOFF     20
`define SFR_BIT_BIOZ_IRQ   19
`define SFR_BIT_BIOZ_OVF   18
`define SFR_BIT_OVER       17
`define SFR_BIT_UNDER      16
`define SFR_BIT_DRV_MON    15
`define SFR_BIT_PACE_IRQ   14
`define SFR_BIT_PACE_OVF   13
`define SFR_BIT_PACING_EDGE_FLAG      12
`define SFR_BIT_LEADS_ON   11
`define SFR_BIT_R_EVENT    10
`define SFR_BIT_BASE_TICK  9
`define SFR_BIT_PLL        8
`define SFR_BIT_DRIVE_POS_OUTPUT       5
`define SFR_BIT_DRIVE_NEG_OUTPUT       4

`define SFR_MASK_RST       16'h0000
`define SFR_CLR_SELF       2'h1
`define SFR_LON_MODE_A     2'h1
`define SFR_LON_MODE_B     2'h2

`define SFR_CLK_KHZ        40000
`define SFR_DCLOFF_MS      90
`define SFR_OVER_MS        100
`define SFR_UNDER_S        1.7
`define SFR_DRV_MON_MS     128

`endif

// ### design/sfr_pkg.sv
// types shared by the status flag unit modules
package sfr_pkg;

  typedef enum logic [1:0] {
    SFR_IDLE,
    SFR_CMD,
    SFR_DATA,
    SFR_WAIT
  } sfr_phase_e;

  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } sfr_timer_s;

  typedef struct packed {
    logic       csb_m;
    logic       csb_s;
    logic       sclk_m;
    logic       sclk_s;
    logic       sclk_p;
    logic       sdi_m;
    logic       sdi_s;
    sfr_phase_e phase;
    logic [5:0]  bit_cnt;
    logic [6:0]  addr;
    logic        rd;
    logic [23:0] shin;
    logic [23:0] shout;
    logic [23:0] snap;
    logic        sdo;
    logic [23:0] flags;
    logic        lon_armed;
    logic [15:0] mask_pri;
    logic [15:0] mask_sec;
    logic        irq_pri_n;
    logic        irq_sec_n;
  } sfr_state_s;

endpackage : sfr_pkg

// ### design/sfr_hold_timer.sv
// persistence timer: reports a condition that has held for a set number of cycles
`timescale 1ns/1ps
module sfr_hold_timer #(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic cond,
  output logic      expired
);

  sfr_pkg::sfr_timer_s q;
  sfr_pkg::sfr_timer_s d;

  // --------------------------------------------------------------------
  // counting
  // --------------------------------------------------------------------
  always_comb begin
    d = q;
    if (!cond) begin
      d.cnt  = 32'h0;
      d.done = 1'b0;
    end else begin
      // saturate so a condition held for hours never wraps back to idle
      if (q.cnt != CYCLES) begin
        d.cnt = q.cnt + 32'h1;
      end
      d.done = (d.cnt == CYCLES);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.done;

endmodule : sfr_hold_timer

// ### design/sfr_top.sv
// status flag unit: serial register port, status flags and interrupt outputs
`timescale 1ns/1ps
`include "sfr_map.svh"
module sfr_top #(
  parameter int unsigned DCLOFF_CYC  = `SFR_DCLOFF_MS * `SFR_CLK_KHZ + 1,
  parameter int unsigned OVER_CYC    = `SFR_OVER_MS * `SFR_CLK_KHZ,
  parameter int unsigned UNDER_CYC   = int'(`SFR_UNDER_S * 1000.0) * `SFR_CLK_KHZ,
  parameter int unsigned DRV_MON_CYC = `SFR_DRV_MON_MS * `SFR_CLK_KHZ
) (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // serial port pins
  input  wire logic       csb_n,
  input  wire logic       sclk,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // measurement channel conditions, core_clk domain
  input  wire logic       ecg_thresh_met,
  input  wire logic       ecg_overflow_evt,
  input  wire logic       fast_recovery_active,
  input  wire logic       dc_lead_off_cond,
  input  wire logic [3:0] dc_lead_off_detail,
  input  wire logic       bioz_thresh_met,
  input  wire logic       bioz_overflow_evt,
  input  wire logic       bioz_above_high,
  input  wire logic       bioz_within_low,
  input  wire logic       drive_pos_lead_off,
  input  wire logic       drive_neg_lead_off,
  input  wire logic       pacing_records_avail,
  input  wire logic       pacing_overflow_evt,
  input  wire logic       pacing_edge_evt,
  input  wire logic       leads_on_cond,
  input  wire logic       r_event_evt,
  input  wire logic       base_rate_tick,
  input  wire logic       pll_locked,
  input  wire logic       channels_enabled,
  input  wire logic       fifo_reset_cmd,
  input  wire logic       resync_command,
  input  wire logic [1:0] low_power_leads_on_mode,
  input  wire logic [1:0] fast_recovery_clear_mode,
  input  wire logic [1:0] pacing_edge_clear_mode,
  input  wire logic [1:0] r_event_clear_mode,
  // outputs
  output logic [23:0]     status_flags,
  output logic            irq_out_primary_n,
  output logic            irq_out_secondary_n
);

  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // --------------------------------------------------------------------
  // persistence timers
  // --------------------------------------------------------------------
  localparam int unsigned NTMR = 5;
  localparam int unsigned TMR_CYC [NTMR] = '{DCLOFF_CYC, OVER_CYC, UNDER_CYC,
                                            DRV_MON_CYC, DRV_MON_CYC};

  logic [NTMR-1:0] tmr_cond;
  logic [NTMR-1:0] tmr_done;

  assign tmr_cond = {drive_neg_lead_off, drive_pos_lead_off, bioz_within_low,
                     bioz_above_high, dc_lead_off_cond};

  for (genvar i = 0; i < NTMR; i++) begin : g_tmr
    sfr_hold_timer #(
      .CYCLES (TMR_CYC[i])
    ) u_tmr (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .cond     (tmr_cond[i]),
      .expired  (tmr_done[i])
    );
  end

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic sticky(input logic prev, input logic set, input logic clr);
    // a set arriving with the clear wins
    sticky = set | (prev & ~clr);
  endfunction : sticky

  sfr_pkg::sfr_state_s q;
  sfr_pkg::sfr_state_s d;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        status_clr;
  logic [23:0] rc;
  logic [23:0] word_in;
  logic [23:0] rd_val;
  logic        ovf_clr;
  logic        lon_mode_on;

  assign sclk_rise   = q.sclk_s & ~q.sclk_p;
  assign sclk_fall   = ~q.sclk_s & q.sclk_p;
  assign word_in     = {q.shin[22:0], q.sdi_s};
  assign ovf_clr     = fifo_reset_cmd | resync_command;
  assign lon_mode_on = (low_power_leads_on_mode == `SFR_LON_MODE_A) ||
                       (low_power_leads_on_mode == `SFR_LON_MODE_B);

  always_comb begin
    rd_val = 24'h0;
    case (q.shin[6:0])
      `SFR_ADDR_STATUS:   rd_val = q.flags;
      `SFR_ADDR_MASK_PRI: rd_val = {q.mask_pri, 8'h00};
      `SFR_ADDR_MASK_SEC: rd_val = {q.mask_sec, 8'h00};
      default:            rd_val = 24'h0;
    endcase
  end

  // --------------------------------------------------------------------
  // serial port and flag logic
  // --------------------------------------------------------------------
  always_comb begin
    d          = q;
    status_clr = 1'b0;
    d.csb_m    = csb_n;
    d.csb_s    = q.csb_m;
    d.sclk_m   = sclk;
    d.sclk_s   = q.sclk_m;
    d.sclk_p   = q.sclk_s;
    d.sdi_m    = sdi;
    d.sdi_s    = q.sdi_m;

    case (q.phase)
      sfr_pkg::SFR_IDLE: begin
        d.sdo = 1'b0;
        if (!q.csb_s) begin
          d.phase   = sfr_pkg::SFR_CMD;
          d.bit_cnt = 6'h0;
        end
      end
      sfr_pkg::SFR_CMD: begin
        if (sclk_rise) begin
          d.shin    = word_in;
          d.bit_cnt = q.bit_cnt + 6'h1;
          if (q.bit_cnt == `SFR_CMD_LAST) begin
            d.addr  = q.shin[6:0];
            d.rd    = q.sdi_s;
            d.shout = q.sdi_s ? rd_val : 24'h0;
            d.snap  = q.flags;
            d.phase = sfr_pkg::SFR_DATA;
          end
        end
      end
      sfr_pkg::SFR_DATA: begin
        if (sclk_fall && q.rd) begin
          d.sdo   = q.shout[23];
          d.shout = {q.shout[22:0], 1'b0};
        end
        if (sclk_rise) begin
          d.shin    = word_in;
          d.bit_cnt = q.bit_cnt + 6'h1;
          if (q.bit_cnt == `SFR_FRAME_LAST) begin
            d.phase = sfr_pkg::SFR_WAIT;
            if (q.rd && q.addr == `SFR_ADDR_STATUS) begin
              status_clr = 1'b1;
            end
            // status and null addresses take no write at all
            if (!q.rd && q.addr == `SFR_ADDR_MASK_PRI) begin
              d.mask_pri = word_in[23:8];
            end
            if (!q.rd && q.addr == `SFR_ADDR_MASK_SEC) begin
              d.mask_sec = word_in[23:8];
            end
          end
        end
      end
      sfr_pkg::SFR_WAIT: begin
        d.sdo = 1'b0;
      end
      default: begin
        d.phase = sfr_pkg::SFR_IDLE;
      end
    endcase

    // deselect ends any frame; a short frame clears and writes nothing
    if (q.csb_s) begin
      d.phase = sfr_pkg::SFR_IDLE;
      d.sdo   = 1'b0;
    end

    // only bits already reported are cleared, so a flag that rises during
    // the read is kept for the next read instead of being lost
    rc = status_clr ? q.snap : 24'h0;

    // level flags track their source directly
    d.flags[`SFR_BIT_ECG_IRQ]  = ecg_thresh_met;
    d.flags[`SFR_BIT_BIOZ_IRQ] = bioz_thresh_met;
    d.flags[`SFR_BIT_PACE_IRQ] = pacing_records_avail;

    // overflow flags clear only by fifo reset or resync
    d.flags[`SFR_BIT_ECG_OVF]  = sticky(q.flags[`SFR_BIT_ECG_OVF],
                                        ecg_overflow_evt, ovf_clr);
    d.flags[`SFR_BIT_BIOZ_OVF] = sticky(q.flags[`SFR_BIT_BIOZ_OVF],
                                        bioz_overflow_evt, ovf_clr);
    d.flags[`SFR_BIT_PACE_OVF] = sticky(q.flags[`SFR_BIT_PACE_OVF],
                                        pacing_overflow_evt, ovf_clr);

    // clear-mode flags: self-clearing or held until a status read
    if (fast_recovery_clear_mode == `SFR_CLR_SELF) begin
      d.flags[`SFR_BIT_FAST] = fast_recovery_active;
    end else begin
      d.flags[`SFR_BIT_FAST] = sticky(q.flags[`SFR_BIT_FAST],
                                      fast_recovery_active, rc[`SFR_BIT_FAST]);
    end
    if (pacing_edge_clear_mode == `SFR_CLR_SELF) begin
      d.flags[`SFR_BIT_PACING_EDGE_FLAG] = pacing_edge_evt;
    end else begin
      d.flags[`SFR_BIT_PACING_EDGE_FLAG] = sticky(q.flags[`SFR_BIT_PACING_EDGE_FLAG],
                                       pacing_edge_evt, rc[`SFR_BIT_PACING_EDGE_FLAG]);
    end
    if (r_event_clear_mode == `SFR_CLR_SELF) begin
      d.flags[`SFR_BIT_R_EVENT] = r_event_evt;
    end else begin
      d.flags[`SFR_BIT_R_EVENT] = sticky(q.flags[`SFR_BIT_R_EVENT],
                                         r_event_evt, rc[`SFR_BIT_R_EVENT]);
    end

    // timed sticky flags
    d.flags[`SFR_BIT_DCLOFF]  = sticky(q.flags[`SFR_BIT_DCLOFF], tmr_done[0],
                                       rc[`SFR_BIT_DCLOFF]);
    d.flags[`SFR_BIT_OVER]    = sticky(q.flags[`SFR_BIT_OVER], tmr_done[1],
                                       rc[`SFR_BIT_OVER]);
    d.flags[`SFR_BIT_UNDER]   = sticky(q.flags[`SFR_BIT_UNDER], tmr_done[2],
                                       rc[`SFR_BIT_UNDER]);
    d.flags[`SFR_BIT_DRIVE_POS_OUTPUT]    = sticky(q.flags[`SFR_BIT_DRIVE_POS_OUTPUT], tmr_done[3],
                                       rc[`SFR_BIT_DRIVE_POS_OUTPUT]);
    d.flags[`SFR_BIT_DRIVE_NEG_OUTPUT]    = sticky(q.flags[`SFR_BIT_DRIVE_NEG_OUTPUT], tmr_done[4],
                                       rc[`SFR_BIT_DRIVE_NEG_OUTPUT]);
    d.flags[`SFR_BIT_DRV_MON] = sticky(q.flags[`SFR_BIT_DRV_MON],
                                       tmr_done[3] | tmr_done[4],
                                       rc[`SFR_BIT_DRV_MON]);
    for (int b = 0; b < 4; b++) begin
      d.flags[b] = sticky(q.flags[b], tmr_done[0] & dc_lead_off_detail[b],
                          rc[b]);
    end

    d.flags[`SFR_BIT_BASE_TICK] = sticky(q.flags[`SFR_BIT_BASE_TICK],
                                         base_rate_tick, rc[`SFR_BIT_BASE_TICK]);
    d.flags[`SFR_BIT_PLL] = sticky(q.flags[`SFR_BIT_PLL],
                                   channels_enabled & ~pll_locked,
                                   rc[`SFR_BIT_PLL]);
    d.flags[7:6] = 2'h0;

    // leads-on: flag raised on entry to the mode, first status read arms
    if (!lon_mode_on) begin
      d.lon_armed                 = 1'b0;
      d.flags[`SFR_BIT_LEADS_ON]  = 1'b0;
    end else if (!q.lon_armed) begin
      d.flags[`SFR_BIT_LEADS_ON] = ~rc[`SFR_BIT_LEADS_ON];
      d.lon_armed                = rc[`SFR_BIT_LEADS_ON];
    end else begin
      d.flags[`SFR_BIT_LEADS_ON] = sticky(q.flags[`SFR_BIT_LEADS_ON],
                                          leads_on_cond,
                                          rc[`SFR_BIT_LEADS_ON]);
    end

    d.irq_pri_n = ~|(d.flags[23:8] & q.mask_pri);
    d.irq_sec_n = ~|(d.flags[23:8] & q.mask_sec);
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q           <= '0;
      q.csb_m     <= 1'b1;
      q.csb_s     <= 1'b1;
      q.phase     <= sfr_pkg::SFR_IDLE;
      q.mask_pri  <= `SFR_MASK_RST;
      q.mask_sec  <= `SFR_MASK_RST;
      q.irq_pri_n <= 1'b1;
      q.irq_sec_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sdo                 = q.sdo;
  assign sdo_oe              = ~q.csb_s;
  assign status_flags        = q.flags;
  assign irq_out_primary_n   = q.irq_pri_n;
  assign irq_out_secondary_n = q.irq_sec_n;

endmodule : sfr_top

// ### testbench/sfr_monitor.sv
// port relation checker for the status flag unit
`timescale 1ns/1ps
module sfr_monitor #(
  parameter int unsigned DCLOFF_CYC  = 10,
  parameter int unsigned OVER_CYC    = 12,
  parameter int unsigned UNDER_CYC   = 20,
  parameter int unsigned DRV_MON_CYC = 8
) (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        csb_n,
  input wire logic        ecg_thresh_met,
  input wire logic        ecg_overflow_evt,
  input wire logic        fast_recovery_active,
  input wire logic        dc_lead_off_cond,
  input wire logic [3:0]  dc_lead_off_detail,
  input wire logic        bioz_thresh_met,
  input wire logic        pacing_records_avail,
  input wire logic        pacing_edge_evt,
  input wire logic        r_event_evt,
  input wire logic        pll_locked,
  input wire logic        channels_enabled,
  input wire logic        fifo_reset_cmd,
  input wire logic        resync_command,
  input wire logic [23:0] status_flags,
  input wire logic        irq_out_primary_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----
  // lead-off persistence count
  // ----
  logic [31:0] lo_cnt_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) lo_cnt_q <= '0;
    else lo_cnt_q <= dc_lead_off_cond ? lo_cnt_q + 32'h1 : 32'h0;
  end
  level_follow_a:
    assert property (status_flags[23] == $past(ecg_thresh_met) && status_flags[19] ==
      $past(bioz_thresh_met) && status_flags[14] == $past(pacing_records_avail))
      else $error("fifo level flag mismatch");
  ovf_set_a:
    assert property (ecg_overflow_evt |=> status_flags[22]) else $error("overflow not set");
  ovf_clear_a:
    assert property ((fifo_reset_cmd || resync_command) && !ecg_overflow_evt
      |=> !status_flags[22]) else $error("overflow not cleared");
  ovf_hold_a:
    assert property (status_flags[22] && !fifo_reset_cmd && !resync_command
      |=> status_flags[22]) else $error("overflow dropped");
  event_set_a:
    assert property ((fast_recovery_active |=> status_flags[21]) and (pacing_edge_evt
      |=> status_flags[12]) and (r_event_evt |=> status_flags[10])) else $error("event lost");
  lead_off_late_a:
    assert property (lo_cnt_q == DCLOFF_CYC + 4 |-> status_flags[20])
      else $error("lead-off flag late");
  lead_off_early_a:
    assert property (lo_cnt_q == DCLOFF_CYC - 2 && !$past(status_flags[20], DCLOFF_CYC - 2)
      |-> !status_flags[20]) else $error("lead-off flag early");
  detail_with_a:
    assert property ($rose(status_flags[20]) |-> status_flags[3:0] == $past(dc_lead_off_detail))
      else $error("detail bits not with lead-off");
  pll_powered_a:
    assert property ($rose(status_flags[8]) |-> $past(channels_enabled && !pll_locked))
      else $error("pll flag without cause");
  sticky_hold_a:
    assert property (csb_n [*6] |=> ($past(status_flags[20:15]) & ~status_flags[20:15]
      & 6'h27) == 6'h00) else $error("sticky flag dropped");
  irq_cause_a:
    assert property (!irq_out_primary_n |-> (|status_flags[23:8]) || $past(|status_flags[23:8]))
      else $error("irq without flag");
endmodule : sfr_monitor

// ### testbench/sfr_host.sv
// serial port master standing in for the host controller
`timescale 1ns/1ps
module sfr_host (
  output logic      csb_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    csb_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end
  // whole 32 clock frame, mode 0, msb first; sdo is taken mid high phase:
  // it lags each falling edge by the synchroniser, and the last bit is
  // dropped soon after the 32nd rise
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic [23:0] wdata,
                      output logic [23:0] rdata, output logic sdo_hi);
    logic [31:0] word;
    word   = {addr, rd, wdata};
    rdata  = '0;
    sdo_hi = 1'b0;
    #7 csb_n = 1'b0;
    for (int i = 0; i < 32; i++) begin
      sdi = word[31 - i];
      #100 sclk = 1'b1;
      #50 sdo_hi = sdo_hi | sdo;
      if (i > 7) rdata[31 - i] = sdo;
      #50 sclk = 1'b0;
    end
    #100 csb_n = 1'b1;
    // a released line never keeps its last level
    sdi = ~sdi;
    #200;
  endtask : xfer
endmodule : sfr_host

// ### testbench/tb_top.sv
// self-checking bench of the status flag unit
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [10:0] d; logic [23:0] q;} sfr_tb_row_s;
  localparam int C_DC = 10, C_OV = 12, C_UN = 20, C_DM = 8;
  logic        core_clk = 1'b0, arst_n = 1'b0, lon = 1'b0, pll_locked = 1'b0, chan_en = 1'b0;
  logic [10:0] drv = '0;
  logic [4:0]  tmr = '0;
  logic [3:0]  det = 4'h9;
  logic [1:0]  lon_mode = '0, cm = 2'h1;
  logic [23:0] status_flags, rdat;
  logic        csb_n, sclk, sdi, sdo, sdo_oe, irq_p_n, irq_s_n, hi;
  int          n_mismatch = 0, n_compared = 0;
  int          cyc_tab [5] = '{C_DC, C_OV, C_UN, C_DM, C_DM};
  int          bit_tab [5] = '{20, 17, 16, 15, 15};
  int          det_tab [5] = '{0, 17, 16, 5, 4};
  sfr_tb_row_s rows [10] = '{'{11'h400, 24'h800000}, '{11'h200, 24'h400000},
    '{11'h0a0, 24'h484000}, '{11'h050, 24'h442000}, '{11'h002, 24'h000000},
    '{11'h201, 24'h400000}, '{11'h001, 24'h000000}, '{11'h100, 24'h200000},
    '{11'h00c, 24'h001400}, '{11'h000, 24'h000000}};
  always #12.5 core_clk = ~core_clk;
  sfr_host i_sfr_host (.csb_n(csb_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
  sfr_top #(.DCLOFF_CYC(C_DC), .OVER_CYC(C_OV), .UNDER_CYC(C_UN), .DRV_MON_CYC(C_DM)) i_sfr_top (
    .core_clk(core_clk), .arst_n(arst_n), .csb_n(csb_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .ecg_thresh_met(drv[10]), .ecg_overflow_evt(drv[9]),
    .fast_recovery_active(drv[8]), .dc_lead_off_cond(tmr[0]), .dc_lead_off_detail(det),
    .bioz_thresh_met(drv[7]), .bioz_overflow_evt(drv[6]), .bioz_above_high(tmr[1]),
    .bioz_within_low(tmr[2]), .drive_pos_lead_off(tmr[3]), .drive_neg_lead_off(tmr[4]),
    .pacing_records_avail(drv[5]), .pacing_overflow_evt(drv[4]), .pacing_edge_evt(drv[3]),
    .leads_on_cond(lon), .r_event_evt(drv[2]), .base_rate_tick(1'b0),
    .pll_locked(pll_locked), .channels_enabled(chan_en), .fifo_reset_cmd(drv[1]),
    .resync_command(drv[0]), .low_power_leads_on_mode(lon_mode),
    .fast_recovery_clear_mode(cm), .pacing_edge_clear_mode(cm), .r_event_clear_mode(cm),
    .status_flags(status_flags), .irq_out_primary_n(irq_p_n), .irq_out_secondary_n(irq_s_n));
  // ----
  // helpers
  // ----
  task automatic chk(input logic [26:0] got, input logic [26:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s", $time, msg);
      n_mismatch++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic rd(input logic [6:0] a);
    i_sfr_host.xfer(a, 1'b1, 24'h0, rdat, hi);
    cyc(2);
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    i_sfr_host.xfer(a, 1'b0, d, rdat, hi);
    cyc(2);
  endtask : wr
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // ----
  // sequence
  // ----
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    cyc(8);
    foreach (rows[k]) begin
      drv = rows[k].d;
      cyc(1);
      chk(status_flags, rows[k].q, "flag row");
      chk({irq_p_n, irq_s_n}, 2'b11, "irq with masks clear");
    end
    drv = 11'h400;
    wr(7'h00, 24'hffffff);
    wr(7'h7f, 24'hffffff);
    chk(irq_p_n, 1'b1, "null write changed mask");
    rd(7'h00);
    chk({hi, rdat}, 25'h0, "null low read");
    rd(7'h7f);
    chk({hi, rdat}, 25'h0, "null high read");
    wr(7'h01, 24'h0);
    rd(7'h01);
    chk(rdat, 24'h800000, "status read");
    wr(7'h02, 24'h800000);
    chk({irq_p_n, irq_s_n}, 2'b01, "masked irq");
    rd(7'h02);
    chk(rdat, 24'h800000, "mask read");
    wr(7'h03, 24'h800000);
    chk({irq_p_n, irq_s_n}, 2'b00, "secondary irq");
    drv = '0;
    cyc(2);
    chk({irq_p_n, irq_s_n}, 2'b11, "irq release");
    for (int k = 0; k < 5; k++) begin
      tmr[k] = 1'b1;
      cyc(cyc_tab[k] - 2);
      chk(status_flags[bit_tab[k]], 1'b0, "timer early");
      cyc(6);
      chk(status_flags[bit_tab[k]], 1'b1, "timer late");
      rd(7'h01);
      chk(rdat[det_tab[k]], 1'b1, "detail bit");
      if (k == 0) chk(rdat[3:0], det, "detail nibble");
      chk(status_flags[bit_tab[k]], 1'b1, "held by source");
      tmr[k] = 1'b0;
      cyc(2);
      chk(status_flags[bit_tab[k]], 1'b1, "sticky");
      rd(7'h01);
      chk(status_flags[bit_tab[k]], 1'b0, "read clear");
    end
    for (int m = 1; m < 3; m++) begin
      lon_mode = m[1:0];
      cyc(3);
      chk(status_flags[11], 1'b1, "leads-on on entry");
      rd(7'h01);
      chk(status_flags[11], 1'b0, "leads-on armed");
      lon = 1'b1;
      cyc(2);
      chk(status_flags[11], 1'b1, "leads-on seen");
      lon = 1'b0;
      cyc(2);
      chk(status_flags[11], 1'b1, "leads-on held");
      rd(7'h01);
      chk(status_flags[11], 1'b0, "leads-on clear");
      lon_mode = 2'h0;
      cyc(2);
    end
    cm = 2'h0;
    drv = 11'h10c;
    cyc(1);
    drv = '0;
    cyc(3);
    chk(status_flags & 24'h201400, 24'h201400, "held events");
    rd(7'h01);
    chk(status_flags & 24'h201400, 24'h0, "events cleared");
    cm = 2'h1;
    chk(status_flags[8], 1'b0, "pll unpowered");
    chan_en = 1'b1;
    cyc(3);
    chk(status_flags[8], 1'b1, "pll unlocked");
    pll_locked = 1'b1;
    cyc(2);
    chk(status_flags[8], 1'b1, "pll held");
    rd(7'h01);
    chk(status_flags[8], 1'b0, "pll cleared");
    // second reset while a mask is set: masks must come back clear
    arst_n = 1'b0;
    cyc(2);
    chk({status_flags, sdo_oe, irq_p_n, irq_s_n}, 27'h3, "reset state");
    arst_n = 1'b1;
    cyc(6);
    drv = 11'h400;
    cyc(2);
    chk({status_flags[23], irq_p_n, irq_s_n}, 3'b111, "mask reset");
    end_sim();
  end
  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end
endmodule : tb_top
bind sfr_top sfr_monitor #(.DCLOFF_CYC(DCLOFF_CYC), .OVER_CYC(OVER_CYC),
  .UNDER_CYC(UNDER_CYC), .DRV_MON_CYC(DRV_MON_CYC)) i_sfr_monitor (
  .core_clk(core_clk), .arst_n(arst_n), .csb_n(csb_n), .ecg_thresh_met(ecg_thresh_met),
  .ecg_overflow_evt(ecg_overflow_evt), .fast_recovery_active(fast_recovery_active),
  .dc_lead_off_cond(dc_lead_off_cond), .dc_lead_off_detail(dc_lead_off_detail),
  .bioz_thresh_met(bioz_thresh_met), .pacing_records_avail(pacing_records_avail),
  .pacing_edge_evt(pacing_edge_evt), .r_event_evt(r_event_evt), .pll_locked(pll_locked),
  .channels_enabled(channels_enabled), .fifo_reset_cmd(fifo_reset_cmd),
  .resync_command(resync_command), .status_flags(status_flags),
  .irq_out_primary_n(irq_out_primary_n));
